// file: rtl/lite_timer_pkg.sv
// Purpose: Shared constants for the dual timebase capture timer
// Assumes: Byte-wide registers on a plain strobe port, clk is the oscillator
// Notes:   Offsets are byte addresses on the register port
package lite_timer_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_TIMEBASE2_CTRL_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RELOAD_VALUE          = 8'h09;
    localparam logic [7:0] ADDR_TIMEBASE2_COUNT       = 8'h0A;
    localparam logic [7:0] ADDR_TIMER_CTRL_STATUS     = 8'h0B;
    localparam logic [7:0] ADDR_CAPTURE_VALUE         = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS            = 8'h0D;
    localparam logic [7:0] ADDR_IRQ_MASK              = 8'h0E;

    // Field positions in timer_ctrl_status
    localparam int BIT_CAPTURE_IRQ_ENABLE    = 7;
    localparam int BIT_CAPTURE_FLAG          = 6;
    localparam int BIT_PERIOD_SELECT         = 5;
    localparam int BIT_FIRST_BASE_IRQ_ENABLE = 4;
    localparam int BIT_FIRST_BASE_FLAG       = 3;

    // Field positions in timebase2_ctrl_status
    localparam int BIT_SECOND_BASE_IRQ_ENABLE = 1;
    localparam int BIT_SECOND_BASE_FLAG       = 0;

    // Field positions in irq_status and irq_mask
    localparam int BIT_EV_FIRST_BASE  = 0;
    localparam int BIT_EV_SECOND_BASE = 1;
    localparam int BIT_EV_CAPTURE     = 2;

    // Reset values
    localparam logic [7:0] RST_COUNT    = 8'h00;
    localparam logic [7:0] RST_RELOAD   = 8'h00;
    localparam logic [7:0] RST_CAPTURE  = 8'h00;
    localparam logic [4:0] RST_PRESCALE = 5'h00;
    localparam logic [2:0] RST_EVENTS   = 3'h0;

    // Timing: counters step once per OSC_DIV oscillator periods
    localparam int         OSC_DIV           = 32;
    localparam int         PERIOD_SHORT_OSC  = 8000;
    localparam int         PERIOD_LONG_OSC   = 16000;
    localparam logic [4:0] PRESCALE_TOP      = 5'(OSC_DIV - 1);
    localparam logic [7:0] FIRST_TOP         = 8'(PERIOD_SHORT_OSC / OSC_DIV - 1);
    localparam logic [7:0] SECOND_TOP        = 8'hFF;
    localparam int         LONG_WRAPS        = PERIOD_LONG_OSC / PERIOD_SHORT_OSC;

endpackage

// file: rtl/timebase_if.sv
// Purpose: Carrier between register logic and the timebase counters
// Assumes: Single clock domain
// Notes:   Events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface timebase_if;
    logic       run;
    logic       period_select;
    logic [7:0] reload;
    logic [7:0] count1;
    logic [7:0] count2;
    logic       tb1_event;
    logic       tb2_event;

    modport core (input run, input period_select, input reload,
                  output count1, output count2, output tb1_event, output tb2_event);
    modport ctrl (output run, output period_select, output reload,
                  input count1, input count2, input tb1_event, input tb2_event);
endinterface
`default_nettype wire

// file: rtl/timebase_counters.sv
// Purpose: Prescaler, fixed-period counter and autoreload counter
// Assumes: clk is the oscillator, run low freezes everything
// Notes:   Long period is made by flagging every second wrap
`timescale 1ns/1ps
`default_nettype none
module timebase_counters
    import lite_timer_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Counter side of the carrier
    timebase_if.core  tb
);

    logic [4:0] prescale_q, prescale_d;
    logic [7:0] count1_q,   count1_d;
    logic [7:0] count2_q,   count2_d;
    logic       half_q,     half_d;
    logic       tick;
    logic       wrap1;
    logic       wrap2;

    // Next values of all counters
    always_comb begin
        tick       = tb.run && (prescale_q == PRESCALE_TOP);
        wrap1      = tick && (count1_q == FIRST_TOP);
        wrap2      = tick && (count2_q == SECOND_TOP);
        prescale_d = prescale_q;
        count1_d   = count1_q;
        count2_d   = count2_q;
        half_d     = half_q;
        if (tb.run) begin                                        // [R17]
            prescale_d = (prescale_q == PRESCALE_TOP) ? RST_PRESCALE : prescale_q + 5'h01;
        end
        if (tick) begin                                          // [R14] [R15]
            count1_d = wrap1 ? RST_COUNT : count1_q + 8'h01;
            count2_d = wrap2 ? tb.reload : count2_q + 8'h01;     // [R02]
        end
        if (wrap1) begin
            half_d = ~half_q;
        end
    end

    // Counter registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_q <= RST_PRESCALE;
            count1_q   <= RST_COUNT;
            count2_q   <= RST_COUNT;                             // [R01]
            half_q     <= 1'b0;
        end else begin
            prescale_q <= prescale_d;
            count1_q   <= count1_d;
            count2_q   <= count2_d;
            half_q     <= half_d;
        end
    end

    // Period select: every wrap, or every second wrap
    assign tb.tb1_event = wrap1 && (!tb.period_select || half_q); // [R06]
    assign tb.tb2_event = wrap2;
    assign tb.count1    = count1_q;
    assign tb.count2    = count2_q;

endmodule
`default_nettype wire

// file: rtl/lite_timer.sv
// Purpose: Dual timebase timer with input capture and register port
// Assumes: Register strobes are one cycle, read data follow one cycle later
// Notes:   Capture pin is asynchronous and is synchronised here
//
// Overview of operation
// [R01] Second counter is readable, not writable, zero after reset.
// [R02] Second counter reloads from the reload register on overflow.
// [R03] Capture flag sets on capture, clears only on reading the capture value.
// [R04] Writing the capture flag bit leaves it unchanged.
// [R05] Software reads capture value once after reset to clear the flag.
// [R06] Period select gives 8000 or 16000 oscillator periods per timebase.
// [R07] First timebase enable gates its interrupt, freely read and written.
// [R08] First flag sets on overflow, clears on reading its control register.
// [R09] Writing the first flag bit has no effect.
// [R10] Capture enable gates the capture interrupt, set and cleared by software.
// [R11] Pin edge latches first counter when capture flag clear; else blocked.
// [R12] Capture value is read-only and zero after reset.
// [R13] Low three control bits are kept clear by software and read zero.
// [R14] First counter runs at oscillator over 32, wraps F9h to 00h.
// [R15] Second counter runs at oscillator over 32, wraps FFh to reload.
// [R16] Second flag sets on overflow, cleared by reading its register.
// [R17] Halt stops both counters; slow and wait do not.
// [R18] Each request is high while its flag and enable are both set.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module lite_timer
    import lite_timer_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Pins and power mode
    input  wire logic       capture_input_pin,
    input  wire logic       halt_mode,
    // Interrupts
    output logic            first_base_irq,
    output logic            second_base_irq,
    output logic            capture_irq,
    output logic            irq
);

    timebase_if tb ();

    // Control and status state
    logic       capture_irq_enable_q,     capture_irq_enable_d;
    logic       capture_flag_q,           capture_flag_d;
    logic       period_select_q,          period_select_d;
    logic       first_base_irq_enable_q,  first_base_irq_enable_d;
    logic       first_base_flag_q,        first_base_flag_d;
    logic       second_base_irq_enable_q, second_base_irq_enable_d;
    logic       second_base_flag_q,       second_base_flag_d;
    logic [7:0] reload_q,                 reload_d;
    logic [7:0] captured_q,               captured_d;
    logic [2:0] irq_status_q,             irq_status_d;
    logic [2:0] irq_mask_q,               irq_mask_d;
    logic [7:0] rdata_q,                  rdata_d;

    // Pin synchroniser and edge history
    logic       pin_meta_q;
    logic       pin_sync_q;
    logic       pin_prev_q;

    logic       capture;
    logic [2:0] events;
    logic [7:0] ctrl1_view;
    logic [7:0] ctrl2_view;

    // Register hit on a strobe
    function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] target);
        hit = strobe && (a == target);
    endfunction

    // Counters
    timebase_counters u_counters (
        .clk   (clk),
        .rst_n (rst_n),
        .tb    (tb.core)
    );

    // Carrier drive
    assign tb.run           = !halt_mode;                       // [R17]
    assign tb.period_select = period_select_q;
    assign tb.reload        = reload_q;

    // Register views, reserved bits zero
    assign ctrl1_view = {capture_irq_enable_q, capture_flag_q, period_select_q,
                         first_base_irq_enable_q, first_base_flag_q, 3'h0}; // [R13]
    assign ctrl2_view = {6'h00, second_base_irq_enable_q, second_base_flag_q};

    // Capture only on a synchronised edge with flag clear
    assign capture = (pin_sync_q ^ pin_prev_q) && !capture_flag_q; // [R11]
    assign events  = {capture, tb.tb2_event, tb.tb1_event};

    // Next values of control, flags and read data
    always_comb begin
        capture_irq_enable_d     = capture_irq_enable_q;
        period_select_d          = period_select_q;
        first_base_irq_enable_d  = first_base_irq_enable_q;
        second_base_irq_enable_d = second_base_irq_enable_q;
        reload_d                 = reload_q;
        irq_mask_d               = irq_mask_q;
        captured_d               = captured_q;
        rdata_d                  = 8'h00;

        // Writable fields; flag bits are not written
        if (hit(wr, addr, ADDR_TIMER_CTRL_STATUS)) begin        // [R04] [R09]
            capture_irq_enable_d    = wdata[BIT_CAPTURE_IRQ_ENABLE];    // [R10]
            period_select_d         = wdata[BIT_PERIOD_SELECT];
            first_base_irq_enable_d = wdata[BIT_FIRST_BASE_IRQ_ENABLE]; // [R07]
        end
        if (hit(wr, addr, ADDR_TIMEBASE2_CTRL_STATUS)) begin
            second_base_irq_enable_d = wdata[BIT_SECOND_BASE_IRQ_ENABLE];
        end
        if (hit(wr, addr, ADDR_RELOAD_VALUE)) begin
            reload_d = wdata;
        end
        if (hit(wr, addr, ADDR_IRQ_MASK)) begin
            irq_mask_d = wdata[2:0];
        end

        // Latch first counter on capture
        if (capture) begin
            captured_d = tb.count1;                             // [R11]
        end

        // Flags: set wins over the clearing read
        capture_flag_d = capture ? 1'b1 :
                         (hit(rd, addr, ADDR_CAPTURE_VALUE) ? 1'b0 : capture_flag_q); // [R03]
        first_base_flag_d = tb.tb1_event ? 1'b1 :
                            (hit(rd, addr, ADDR_TIMER_CTRL_STATUS) ? 1'b0 : first_base_flag_q); // [R08]
        second_base_flag_d = tb.tb2_event ? 1'b1 :
                             (hit(rd, addr, ADDR_TIMEBASE2_CTRL_STATUS) ? 1'b0 : second_base_flag_q); // [R16]

        // Sticky event status, write one to clear, set wins
        irq_status_d = (irq_status_q & ~(hit(wr, addr, ADDR_IRQ_STATUS) ? wdata[2:0] : 3'h0)) | events;

        // Read mux, unmapped reads zero
        if (rd) begin
            case (addr)
                ADDR_TIMEBASE2_CTRL_STATUS: rdata_d = ctrl2_view;
                ADDR_RELOAD_VALUE:          rdata_d = reload_q;
                ADDR_TIMEBASE2_COUNT:       rdata_d = tb.count2;         // [R01]
                ADDR_TIMER_CTRL_STATUS:     rdata_d = ctrl1_view;
                ADDR_CAPTURE_VALUE:         rdata_d = captured_q;        // [R12]
                ADDR_IRQ_STATUS:            rdata_d = {5'h00, irq_status_q};
                ADDR_IRQ_MASK:              rdata_d = {5'h00, irq_mask_q};
                default:                    rdata_d = 8'h00;
            endcase
        end
    end

    // Control and status registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_irq_enable_q     <= 1'b0;
            capture_flag_q           <= 1'b0;
            period_select_q          <= 1'b0;
            first_base_irq_enable_q  <= 1'b0;
            first_base_flag_q        <= 1'b0;
            second_base_irq_enable_q <= 1'b0;
            second_base_flag_q       <= 1'b0;
            reload_q                 <= RST_RELOAD;
            captured_q               <= RST_CAPTURE;                     // [R12]
            irq_status_q             <= RST_EVENTS;
            irq_mask_q               <= RST_EVENTS;
            rdata_q                  <= 8'h00;
        end else begin
            capture_irq_enable_q     <= capture_irq_enable_d;
            capture_flag_q           <= capture_flag_d;
            period_select_q          <= period_select_d;
            first_base_irq_enable_q  <= first_base_irq_enable_d;
            first_base_flag_q        <= first_base_flag_d;
            second_base_irq_enable_q <= second_base_irq_enable_d;
            second_base_flag_q       <= second_base_flag_d;
            reload_q                 <= reload_d;
            captured_q               <= captured_d;
            irq_status_q             <= irq_status_d;
            irq_mask_q               <= irq_mask_d;
            rdata_q                  <= rdata_d;
        end
    end

    // Two-stage synchroniser, then edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            pin_meta_q <= capture_input_pin;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // Outputs
    assign rdata           = rdata_q;
    assign first_base_irq  = first_base_flag_q && first_base_irq_enable_q;   // [R18]
    assign second_base_irq = second_base_flag_q && second_base_irq_enable_q; // [R18]
    assign capture_irq     = capture_flag_q && capture_irq_enable_q;         // [R18]
    assign irq             = |(irq_status_q & irq_mask_q);

endmodule
`default_nettype wire

// file: test/lite_timer_assertions.sv
// Purpose: Port-level checks for the lite timer
// Assumes: Read data answer one cycle after the strobe
// Notes:   Bound to the design from the bench top
`timescale 1ns/1ps
`default_nettype none
module lite_timer_assertions (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    // Pins and interrupts
    input wire logic       capture_input_pin,
    input wire logic       halt_mode,
    input wire logic       first_base_irq,
    input wire logic       second_base_irq,
    input wire logic       capture_irq,
    input wire logic       irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Decoded accesses
    wire rc1  = rd && addr == 8'h0B;
    wire rc2  = rd && addr == 8'h08;
    wire rct  = rd && addr == 8'h0A;
    wire rrl  = rd && addr == 8'h09;
    wire wrl  = wr && addr == 8'h09;
    wire wc1  = wr && addr == 8'h0B;
    wire rsts = rd && addr == 8'h0D;
    wire rmk  = rd && addr == 8'h0E;

    AST_RSVD_ZERO: assert property ($past(rc1) |-> rdata[2:0] == 3'h0)
        else $error("reserved control bits read nonzero");
    AST_IRQ_FIRST: assert property ($past(rc1) |-> (rdata[3] & rdata[4]) == $past(first_base_irq))
        else $error("first request disagrees with flag and enable");
    AST_IRQ_CAPTURE: assert property ($past(rc1) |-> (rdata[6] & rdata[7]) == $past(capture_irq))
        else $error("capture request disagrees with flag and enable");
    AST_IRQ_SECOND: assert property ($past(rc2) |-> (rdata[0] & rdata[1]) == $past(second_base_irq))
        else $error("second request disagrees with flag and enable");
    AST_RELOAD_RW: assert property (wrl ##1 rrl |=> rdata == $past(wdata, 2))
        else $error("reload readback differs from write");
    AST_CTRL_RW: assert property (wc1 ##1 rc1 |=> (rdata & 8'hB0) == ($past(wdata, 2) & 8'hB0))
        else $error("control bits readback differs from write");
    AST_HALT_FREEZE: assert property (rct && halt_mode ##1 rct |=> rdata == $past(rdata))
        else $error("second counter moved during halt");
    AST_COUNT_STEP: assert property (rct ##1 rct |=> rdata == $past(rdata)
        || rdata == $past(rdata) + 8'h01 || $past(rdata) == 8'hFF)
        else $error("second counter jumped");
    AST_IRQ_SUM: assert property (rsts ##1 rmk |=> $past(irq, 2) == |(rdata & $past(rdata)))
        else $error("summary interrupt disagrees with status and mask");
endmodule
`default_nettype wire

// file: test/capture_pin_model.sv
// Purpose: Far-side driver of the capture input pin
// Assumes: Push-pull source, always driven
// Notes:   Edges come when the bench asks
`timescale 1ns/1ps
`default_nettype none
module capture_pin_model (
    // Clock
    input  wire logic clk,
    // Pin
    output var logic  pin
);
    // Pin rests low until the first edge
    initial pin = 1'b0;
    // Toggle after n cycles, prompt or slow
    task automatic flip(input int n);
        repeat (n) @(posedge clk);
        pin <= ~pin;
    endtask
endmodule
`default_nettype wire

// file: test/lite_timer_tb.sv
// Purpose: Self-checking bench for the lite timer
// Assumes: Bench drives on rising edges by non-blocking assignment
// Notes:   Tick model counts running clock edges
`timescale 1ns/1ps
`default_nettype none
module lite_timer_tb;
    logic        clk, rst_n, wr, rd, halt_mode, irq, pin, i1, i2, ic;
    logic [7:0]  addr, wdata, rdata, v, w, rl;
    logic [7:0]  eq [$];
    logic [31:0] sd = 73422;
    int          n_errors = 0;
    int          tests_run = 0;
    int          run, r0, k, nf;
    localparam logic [7:0] RA [8] = '{8'h0C, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h20};

    lite_timer i_lite_timer (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .capture_input_pin(pin), .halt_mode(halt_mode),
        .first_base_irq(i1), .second_base_irq(i2), .capture_irq(ic), .irq(irq));
    capture_pin_model i_capture_pin_model (.clk(clk), .pin(pin));

    // Clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Running edges since reset
    always @(posedge clk) run <= !rst_n ? 0 : run + (halt_mode ? 0 : 1);

    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Second counter expected at a running-edge count
    function automatic logic [7:0] c2(input int r);
        return r / 32 < 256 ? 8'(r / 32) : 8'(rl + (r / 32 - 256) % (256 - rl));
    endfunction
    task automatic chk(input logic [7:0] s, x);
        tests_run++;
        if (s !== x) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic results();
        if (n_errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic cy(input logic w_, r_, input logic [7:0] a, d);
        @(posedge clk);
        wr <= w_;
        rd <= r_;
        addr <= a;
        wdata <= d;
    endtask
    task automatic rd1(input logic [7:0] a);
        cy(0, 1, a, 8'h00);
        #1 r0 = run;
        cy(0, 0, 8'h00, 8'h00);
        #1 v = rdata;
    endtask
    task automatic rd2(input logic [7:0] a, b);
        cy(0, 1, a, 8'h00);
        #1 r0 = run;
        cy(0, 1, b, 8'h00);
        #1 w = rdata;
        cy(0, 0, 8'h00, 8'h00);
        #1 v = rdata;
    endtask
    task automatic wr1(input logic [7:0] a, d);
        cy(1, 0, a, d);
        cy(0, 0, 8'h00, 8'h00);
    endtask
    task automatic wrrd(input logic [7:0] a, d);
        cy(1, 0, a, d);
        rd1(a);
    endtask
    // Wait off-edge for a count in mid tick
    task automatic al(input int t);
        while (run < t || run % 32 != 8) @(negedge clk);
    endtask

    // Watchdog
    initial begin
        #(25 * 45000);
        n_errors++;
        results();
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        {wr, rd, halt_mode, addr, wdata} = 19'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, capture value read first to settle its flag
        for (k = 0; k < 8; k++) begin
            rd1(RA[k]);
            chk(v, 8'h00);
        end
        wr1(8'h0E, 8'h07);
        wrrd(8'h08, 8'h03);
        chk(v, 8'h02);
        // Random reload values
        for (k = 0; k < 4; k++) begin
            sd = nx(sd);
            rl = sd[7:0] & 8'h7F;
            wrrd(8'h09, rl);
            chk(v, rl);
        end
        // Random control, flag bits written high, low bits kept clear
        sd = nx(sd);
        wrrd(8'h0B, (sd[7:0] & 8'hB0) | 8'h48);
        chk(v, sd[7:0] & 8'hB0);
        wr1(8'h0B, 8'h90);
        // Halt for a random span
        @(posedge clk);
        halt_mode <= 1'b1;
        repeat (int'(sd[3:0]) + 2) @(posedge clk);
        rd2(8'h0A, 8'h0A);
        chk(v, c2(r0));
        @(posedge clk);
        halt_mode <= 1'b0;
        // Capture, then a blocked edge, then a fresh capture
        for (k = 0; k < 2; k++) begin
            al(0);
            eq.push_back(8'((run / 32) % 250));
            i_capture_pin_model.flip(1);
            repeat (8) @(posedge clk);
            chk({7'h0, ic}, 8'h01);
            wrrd(8'h0B, 8'h90);
            chk(v, 8'hD0);
            i_capture_pin_model.flip(k * 20 + 3);
            repeat (8) @(posedge clk);
            rd1(8'h0C);
            chk(v, eq.pop_front());
            chk({7'h0, ic}, 8'h00);
            rd1(8'h0B);
            chk(v, 8'h90);
        end
        // First timebase overflow
        al(8000);
        chk({7'h0, i1}, 8'h01);
        rd1(8'h0B);
        chk(v, 8'h98);
        chk({7'h0, i1}, 8'h00);
        // Second timebase overflow and reload
        al(8224);
        chk({7'h0, i2}, 8'h01);
        rd1(8'h08);
        chk(v, 8'h03);
        chk({7'h0, i2}, 8'h00);
        rd2(8'h0A, 8'h0A);
        chk(w, c2(r0));
        // Status, mask and write-one-clear
        rd2(8'h0D, 8'h0E);
        chk(w, 8'h07);
        chk({7'h0, irq}, 8'h01);
        wr1(8'h0D, 8'h05);
        rd1(8'h0D);
        chk(v, 8'h02);
        wr1(8'h0E, 8'h00);
        #1 chk({7'h0, irq}, 8'h00);
        // Long period flags every second wrap
        wr1(8'h0B, 8'h20);
        nf = 0;
        for (k = 2; k < 6; k++) begin
            al(8000 * k);
            rd1(8'h0B);
            nf += int'(v[3]);
        end
        chk(8'(nf), 8'h02);
        results();
    end
endmodule
bind lite_timer lite_timer_assertions i_lite_timer_assertions (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .capture_input_pin(capture_input_pin),
    .halt_mode(halt_mode), .first_base_irq(first_base_irq), .second_base_irq(second_base_irq),
    .capture_irq(capture_irq), .irq(irq));
`default_nettype wire
